// ==== core/crg_pkg.sv ====
// Constants and types for the core register and addressing block.
// Assumes one core clock domain and a synchronous active-high reset.
`default_nettype none

package crg_pkg;

  // Special-register direct addresses
  localparam logic [7:0] CRG_ADR_ACCUM   = 8'he0;
  localparam logic [7:0] CRG_ADR_OPND    = 8'hf0;
  localparam logic [7:0] CRG_ADR_EXTOP   = 8'hf1;
  localparam logic [7:0] CRG_ADR_STATUS  = 8'hd0;
  localparam logic [7:0] CRG_ADR_STACK   = 8'h81;
  localparam logic [7:0] CRG_ADR_PLO0    = 8'h82;
  localparam logic [7:0] CRG_ADR_PHI0    = 8'h83;
  localparam logic [7:0] CRG_ADR_PLO1    = 8'h84;
  localparam logic [7:0] CRG_ADR_PHI1    = 8'h85;
  localparam logic [7:0] CRG_ADR_ICFG    = 8'h86;
  localparam logic [7:0] CRG_ADR_EXT_RAM_PAGE_SELECT   = 8'hf7;

  // Status word field positions
  localparam int CRG_ST_CARRY  = 7;
  localparam int CRG_ST_AUX    = 6;
  localparam int CRG_ST_USER0  = 5;
  localparam int CRG_ST_BANKHI = 4;
  localparam int CRG_ST_BANKLO = 3;
  localparam int CRG_ST_RANGE  = 2;
  localparam int CRG_ST_USER1  = 1;
  localparam int CRG_ST_PARITY = 0;

  // Instruction configuration field positions
  localparam int CRG_IC_QWIDTH = 3;
  localparam int CRG_IC_PWIDTH = 2;
  localparam int CRG_IC_PSEL   = 0;

  // Reset values
  localparam logic [7:0]  CRG_RST_STACK = 8'h07;
  localparam logic [7:0]  CRG_RST_BYTE  = 8'h00;
  localparam logic [15:0] CRG_RST_WORD  = 16'h0000;

  // Arithmetic operations
  typedef enum logic [2:0] {
    CRG_OP_ADD  = 3'h0,
    CRG_OP_ADDC = 3'h1,
    CRG_OP_SUBB = 3'h2,
    CRG_OP_MULT = 3'h3,
    CRG_OP_QUOT = 3'h4,
    CRG_OP_AND  = 3'h5,
    CRG_OP_OR   = 3'h6,
    CRG_OP_XOR  = 3'h7
  } crg_op_t;

  // Operand addressing modes
  typedef enum logic [2:0] {
    CRG_AM_DIRECT   = 3'h0,
    CRG_AM_INDIRECT = 3'h1,
    CRG_AM_BANKREG  = 3'h2,
    CRG_AM_XRI      = 3'h3,
    CRG_AM_XPTR     = 3'h4
  } crg_mode_t;

  // Memory space selected by the decoder
  typedef enum logic [1:0] {
    CRG_SP_NONE = 2'h0,
    CRG_SP_IRAM = 2'h1,
    CRG_SP_SFR  = 2'h2,
    CRG_SP_XRAM = 2'h3
  } crg_space_t;

  // Whole register state of the block
  typedef struct packed {
    logic [7:0]  accumulator_reg;
    logic [7:0]  second_operand_reg;
    logic [7:0]  extended_operand_reg;
    logic [7:0]  stack_pointer;
    logic [15:0] first_data_pointer;
    logic [15:0] second_data_pointer;
    logic        carry_flag;
    logic        aux_carry_flag;
    logic        user_flag_zero;
    logic [1:0]  bank_select_field;
    logic        arith_range_flag;
    logic        user_flag_one;
    logic        pointer_select_bit;
    logic        product_width_select;
    logic        quotient_width_select;
    logic        ext_ram_page_select;
    logic [7:0]  rdata;
    logic [15:0] mem_addr;
    crg_space_t  mem_space;
    logic        mem_valid;
  } crg_state_t;

endpackage

`default_nettype wire

// ==== core/crg_core_regs.sv ====
// Core special registers, arithmetic flags and RAM address decoding.
// Assumes the instruction sequencer drives one-cycle request strobes.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RL1] Stack pointer 8-bit, pre-increments on push
// [RL2] Stack pointer post-decrements on pop
// [RL3] Reset loads stack pointer with 07H
// [RL4] Stack addresses full 256-byte internal RAM
// [RL5] Parity bit read-only, odd ones give 1
// [RL6] Bank bits map R0-R7 to four banks
// [RL7] Carry flag follows carry or borrow
// [RL8] Range flag follows overflow
// [RL9] Two user flags freely read and written
// [RL10] Pointers accessible as word or bytes
// [RL11] Reset selects 8-bit multiply and divide
// [RL12] Narrow multiply: low to A, high to B
// [RL13] Wide multiply spreads product over three registers
// [RL14] Narrow divide: quotient A, remainder B
// [RL15] Wide divide uses extended register dividend
// [RL16] Config bit3 divide width, bit2 multiply width
// [RL17] Config bit0 selects active data pointer
// [RL18] Low RAM reached directly and indirectly
// [RL19] Upper RAM indirect only; direct hits registers
// [RL20] Registers direct only; unused addresses hold nothing
// [RL21] External RAM via indirect register or pointer
// [RL22] Page bit gives high byte for register form
// [RL23] Aux carry from bit 3 on add/subtract
// [RL24] Operand registers are scratch otherwise
module crg_core_regs
  import crg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        alu_go,
  input  wire crg_op_t     alu_op,
  input  wire logic [7:0]  alu_operand,
  input  wire logic        first_data_pointer_load,
  input  wire logic [15:0] first_data_pointer_value,
  output logic      [15:0] first_data_pointer_active,
  input  wire logic        stk_push,
  input  wire logic        stk_pop,
  input  wire logic        mem_req,
  input  wire crg_mode_t   mem_mode,
  input  wire logic [7:0]  mem_offset,
  output logic      [15:0] mem_addr,
  output crg_space_t       mem_space,
  output logic             mem_valid,
  output logic      [7:0]  accumulator_out,
  output logic             parity_flag,
  output logic             carry_out
);
  crg_state_t st_reg;   // Registered state
  crg_state_t st_next;  // Next state
  // Arithmetic intermediates
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [8:0]  dif9;
  logic [4:0]  dif5;
  logic [15:0] prod8;
  logic [23:0] prod16;
  logic [15:0] wide_dividend;
  logic [15:0] quot16;
  logic [15:0] rem16;
  logic [7:0]  quot8;
  logic [7:0]  rem8;
  logic        cin;
  // Known special-register addresses; others hold no storage
  function automatic logic sfr_known(input logic [7:0] a);
    case (a)
      CRG_ADR_ACCUM, CRG_ADR_OPND, CRG_ADR_EXTOP, CRG_ADR_STATUS,
      CRG_ADR_STACK, CRG_ADR_PLO0, CRG_ADR_PHI0, CRG_ADR_PLO1,
      CRG_ADR_PHI1, CRG_ADR_ICFG, CRG_ADR_EXT_RAM_PAGE_SELECT: sfr_known = 1'b1;
      default: sfr_known = 1'b0;
    endcase
  endfunction
  // Status word image with live parity
  function automatic logic [7:0] status_word(input crg_state_t s);
    logic [7:0] w;
    w = 8'h00;
    w[CRG_ST_CARRY]  = s.carry_flag;
    w[CRG_ST_AUX]    = s.aux_carry_flag;
    w[CRG_ST_USER0]  = s.user_flag_zero;
    w[CRG_ST_BANKHI] = s.bank_select_field[1];
    w[CRG_ST_BANKLO] = s.bank_select_field[0];
    w[CRG_ST_RANGE]  = s.arith_range_flag;
    w[CRG_ST_USER1]  = s.user_flag_one;
    w[CRG_ST_PARITY] = ^s.accumulator_reg;  // RL5
    status_word = w;
  endfunction
  // Active pointer value
  function automatic logic [15:0] act_ptr(input crg_state_t s);
    act_ptr = s.pointer_select_bit ? s.second_data_pointer
                                   : s.first_data_pointer;
  endfunction
  // Adders, multipliers and dividers, all single cycle
  always_comb begin
    cin    = (alu_op != CRG_OP_ADD) & st_reg.carry_flag;
    sum9   = {1'b0, st_reg.accumulator_reg} + {1'b0, alu_operand}
             + {8'h00, cin};
    sum5   = {1'b0, st_reg.accumulator_reg[3:0]}
             + {1'b0, alu_operand[3:0]} + {4'h0, cin};
    dif9   = {1'b0, st_reg.accumulator_reg} - {1'b0, alu_operand}
             - {8'h00, cin};
    dif5   = {1'b0, st_reg.accumulator_reg[3:0]}
             - {1'b0, alu_operand[3:0]} - {4'h0, cin};
    prod8  = st_reg.accumulator_reg * st_reg.second_operand_reg;
    wide_dividend = {st_reg.extended_operand_reg, st_reg.accumulator_reg};
    prod16 = wide_dividend * st_reg.second_operand_reg;
    // Zero divisor guarded; results then unused
    if (st_reg.second_operand_reg != 8'h00) begin
      quot16 = wide_dividend / {8'h00, st_reg.second_operand_reg};
      rem16  = wide_dividend % {8'h00, st_reg.second_operand_reg};
      quot8  = st_reg.accumulator_reg / st_reg.second_operand_reg;
      rem8   = st_reg.accumulator_reg % st_reg.second_operand_reg;
    end else begin
      quot16 = 16'h0000;
      rem16  = 16'h0000;
      quot8  = 8'h00;
      rem8   = 8'h00;
    end
  end
  // Next-state logic: register writes, then arithmetic, then stack
  always_comb begin
    st_next = st_reg;
    st_next.mem_valid = 1'b0;
    // Direct register writes; unknown addresses are dropped
    if (sfr_wr) begin  // RL20
      case (sfr_addr)
        CRG_ADR_ACCUM: st_next.accumulator_reg = sfr_wdata;
        CRG_ADR_OPND:  st_next.second_operand_reg = sfr_wdata;  // RL24
        CRG_ADR_EXTOP: st_next.extended_operand_reg = sfr_wdata;  // RL24
        CRG_ADR_STACK: st_next.stack_pointer = sfr_wdata;
        CRG_ADR_PLO0:  st_next.first_data_pointer[7:0] = sfr_wdata;  // RL10
        CRG_ADR_PHI0:  st_next.first_data_pointer[15:8] = sfr_wdata;  // RL10
        CRG_ADR_PLO1:  st_next.second_data_pointer[7:0] = sfr_wdata;
        CRG_ADR_PHI1:  st_next.second_data_pointer[15:8] = sfr_wdata;
        CRG_ADR_STATUS: begin
          st_next.carry_flag        = sfr_wdata[CRG_ST_CARRY];
          st_next.aux_carry_flag    = sfr_wdata[CRG_ST_AUX];
          st_next.user_flag_zero    = sfr_wdata[CRG_ST_USER0];  // RL9
          st_next.bank_select_field = sfr_wdata[CRG_ST_BANKHI:CRG_ST_BANKLO];
          st_next.arith_range_flag  = sfr_wdata[CRG_ST_RANGE];
          st_next.user_flag_one     = sfr_wdata[CRG_ST_USER1];  // RL9
        end
        CRG_ADR_ICFG: begin  // RL16
          st_next.quotient_width_select = sfr_wdata[CRG_IC_QWIDTH];
          st_next.product_width_select  = sfr_wdata[CRG_IC_PWIDTH];
          st_next.pointer_select_bit    = sfr_wdata[CRG_IC_PSEL];
        end
        CRG_ADR_EXT_RAM_PAGE_SELECT: st_next.ext_ram_page_select = sfr_wdata[0];  // RL22
        default: ;
      endcase
    end
    // Whole-word load of the selected pointer
    if (first_data_pointer_load) begin  // RL10
      if (st_reg.pointer_select_bit) begin  // RL17
        st_next.second_data_pointer = first_data_pointer_value;
      end else begin
        st_next.first_data_pointer = first_data_pointer_value;
      end
    end
    // Arithmetic overrides a same-cycle register write
    if (alu_go) begin
      case (alu_op)
        CRG_OP_ADD, CRG_OP_ADDC: begin
          st_next.accumulator_reg  = sum9[7:0];
          st_next.carry_flag       = sum9[8];  // RL7
          st_next.aux_carry_flag   = sum5[4];  // RL23
          st_next.arith_range_flag = (st_reg.accumulator_reg[7] ==
            alu_operand[7]) & (sum9[7] != alu_operand[7]);  // RL8
        end
        CRG_OP_SUBB: begin
          st_next.accumulator_reg  = dif9[7:0];
          st_next.carry_flag       = dif9[8];  // RL7
          st_next.aux_carry_flag   = dif5[4];  // RL23
          st_next.arith_range_flag = (st_reg.accumulator_reg[7] !=
            alu_operand[7]) & (dif9[7] != st_reg.accumulator_reg[7]);  // RL8
        end
        CRG_OP_MULT: begin
          st_next.carry_flag = 1'b0;  // RL7
          if (st_reg.product_width_select) begin  // RL13
            st_next.accumulator_reg      = prod16[7:0];
            st_next.second_operand_reg   = prod16[15:8];
            st_next.extended_operand_reg = prod16[23:16];
            st_next.arith_range_flag     = prod16[23:16] != 8'h00;  // RL8
          end else begin  // RL12
            st_next.accumulator_reg    = prod8[7:0];
            st_next.second_operand_reg = prod8[15:8];
            st_next.arith_range_flag   = prod8[15:8] != 8'h00;  // RL8
          end
        end
        CRG_OP_QUOT: begin
          st_next.carry_flag       = 1'b0;  // RL7
          st_next.arith_range_flag = st_reg.second_operand_reg == 8'h00;
          // Divide by zero leaves the operands unchanged
          if (st_reg.second_operand_reg == 8'h00) begin
            st_next.accumulator_reg = st_reg.accumulator_reg;
          end else if (st_reg.quotient_width_select) begin  // RL15
            st_next.accumulator_reg      = quot16[7:0];
            st_next.second_operand_reg   = rem16[7:0];
            st_next.extended_operand_reg = quot16[15:8];
          end else begin  // RL14
            st_next.accumulator_reg    = quot8;
            st_next.second_operand_reg = rem8;
          end
        end
        CRG_OP_AND: st_next.accumulator_reg =
          st_reg.accumulator_reg & alu_operand;
        CRG_OP_OR:  st_next.accumulator_reg =
          st_reg.accumulator_reg | alu_operand;
        CRG_OP_XOR: st_next.accumulator_reg =
          st_reg.accumulator_reg ^ alu_operand;
        default: ;
      endcase
    end
    // Operand address decode
    if (mem_req) begin
      st_next.mem_valid = 1'b1;
      case (mem_mode)
        CRG_AM_DIRECT: begin
          st_next.mem_addr = {8'h00, mem_offset};
          if (!mem_offset[7]) begin  // RL18
            st_next.mem_space = CRG_SP_IRAM;
          end else if (sfr_known(mem_offset)) begin  // RL19
            st_next.mem_space = CRG_SP_SFR;
          end else begin  // RL20
            st_next.mem_space = CRG_SP_NONE;
          end
        end
        CRG_AM_INDIRECT: begin  // RL18 RL19
          st_next.mem_addr  = {8'h00, mem_offset};
          st_next.mem_space = CRG_SP_IRAM;
        end
        CRG_AM_BANKREG: begin  // RL6
          st_next.mem_addr  = {8'h00, 3'b000, st_reg.bank_select_field,
                               mem_offset[2:0]};
          st_next.mem_space = CRG_SP_IRAM;
        end
        CRG_AM_XRI: begin  // RL21 RL22
          st_next.mem_addr  = {7'h00, st_reg.ext_ram_page_select,
                               mem_offset};
          st_next.mem_space = CRG_SP_XRAM;
        end
        CRG_AM_XPTR: begin  // RL21 RL17
          st_next.mem_addr  = act_ptr(st_reg);
          st_next.mem_space = CRG_SP_XRAM;
        end
        default: begin
          st_next.mem_space = CRG_SP_NONE;
          st_next.mem_valid = 1'b0;
        end
      endcase
    end
    // Stack access wins over decode and register writes
    if (stk_push) begin  // RL1 RL4
      st_next.stack_pointer = st_reg.stack_pointer + 8'h01;
      st_next.mem_addr  = {8'h00, st_reg.stack_pointer + 8'h01};
      st_next.mem_space = CRG_SP_IRAM;
      st_next.mem_valid = 1'b1;
    end else if (stk_pop) begin  // RL2 RL4
      st_next.stack_pointer = st_reg.stack_pointer - 8'h01;
      st_next.mem_addr  = {8'h00, st_reg.stack_pointer};
      st_next.mem_space = CRG_SP_IRAM;
      st_next.mem_valid = 1'b1;
    end
    // Register read, registered one cycle later
    if (sfr_rd) begin
      case (sfr_addr)
        CRG_ADR_ACCUM:  st_next.rdata = st_reg.accumulator_reg;
        CRG_ADR_OPND:   st_next.rdata = st_reg.second_operand_reg;
        CRG_ADR_EXTOP:  st_next.rdata = st_reg.extended_operand_reg;
        CRG_ADR_STACK:  st_next.rdata = st_reg.stack_pointer;
        CRG_ADR_PLO0:   st_next.rdata = st_reg.first_data_pointer[7:0];
        CRG_ADR_PHI0:   st_next.rdata = st_reg.first_data_pointer[15:8];
        CRG_ADR_PLO1:   st_next.rdata = st_reg.second_data_pointer[7:0];
        CRG_ADR_PHI1:   st_next.rdata = st_reg.second_data_pointer[15:8];
        CRG_ADR_STATUS: st_next.rdata = status_word(st_reg);  // RL5
        CRG_ADR_ICFG:   st_next.rdata = {4'h0,
          st_reg.quotient_width_select, st_reg.product_width_select,
          1'b0, st_reg.pointer_select_bit};
        CRG_ADR_EXT_RAM_PAGE_SELECT:  st_next.rdata = {7'h00, st_reg.ext_ram_page_select};
        default:        st_next.rdata = CRG_RST_BYTE;  // RL20
      endcase
    end
  end
  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.stack_pointer <= CRG_RST_STACK;  // RL3
      st_reg.product_width_select <= 1'b0;  // RL11
      st_reg.quotient_width_select <= 1'b0;  // RL11
      st_reg.mem_space <= CRG_SP_NONE;
    end else begin
      st_reg <= st_next;
    end
  end
  // Outputs
  assign sfr_rdata       = st_reg.rdata;
  assign first_data_pointer_active     = act_ptr(st_reg);  // RL17
  assign mem_addr        = st_reg.mem_addr;
  assign mem_space       = st_reg.mem_space;
  assign mem_valid       = st_reg.mem_valid;
  assign accumulator_out = st_reg.accumulator_reg;
  assign parity_flag     = ^st_reg.accumulator_reg;  // RL5
  assign carry_out       = st_reg.carry_flag;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_stack_push_inc: assert property (stk_push |=> // RL1
    st_reg.stack_pointer == $past(st_reg.stack_pointer) + 8'h01 &&
    mem_addr[7:0] == st_reg.stack_pointer && mem_space == CRG_SP_IRAM)
    else $error("push did not pre-increment stack pointer");
  a_stack_pop_dec: assert property (stk_pop && !stk_push |=> // RL2
    mem_addr[7:0] == $past(st_reg.stack_pointer) &&
    st_reg.stack_pointer == mem_addr[7:0] - 8'h01)
    else $error("pop did not post-decrement stack pointer");
  a_stack_reset: assert property ($past(sys_rst) |-> // RL3
    st_reg.stack_pointer == 8'h07 && !st_reg.product_width_select)
    else $error("stack pointer not 07H after reset");
  a_parity_read: assert property ( // RL5
    sfr_rd && sfr_addr == CRG_ADR_STATUS |=>
    sfr_rdata[0] == ^$past(st_reg.accumulator_reg))
    else $error("parity bit wrong");
  a_bank_map: assert property ( // RL6
    mem_req && mem_mode == CRG_AM_BANKREG && !stk_push && !stk_pop |=>
    mem_addr[7:0] == {3'b000, $past(st_reg.bank_select_field),
    $past(mem_offset[2:0])})
    else $error("bank register address wrong");
  a_add_carry: assert property ( // RL7
    alu_go && alu_op == CRG_OP_ADD |=> carry_out ==
    (({1'b0, $past(accumulator_out)} + {1'b0, $past(alu_operand)})
    > 9'h0ff))
    else $error("add carry wrong");
  a_mult_narrow: assert property ( // RL12
    alu_go && alu_op == CRG_OP_MULT && !st_reg.product_width_select |=>
    {st_reg.second_operand_reg, accumulator_out} == $past(accumulator_out)
    * $past(st_reg.second_operand_reg) &&
    st_reg.arith_range_flag == |st_reg.second_operand_reg)
    else $error("narrow multiply result wrong");
  a_div_narrow: assert property ( // RL14
    alu_go && alu_op == CRG_OP_QUOT && !st_reg.quotient_width_select &&
    st_reg.second_operand_reg != 8'h00 |=> !st_reg.arith_range_flag &&
    accumulator_out == $past(accumulator_out) /
    $past(st_reg.second_operand_reg))
    else $error("narrow divide result wrong");
  a_direct_upper: assert property ( // RL19
    mem_req && mem_mode == CRG_AM_DIRECT && mem_offset[7] &&
    !stk_push && !stk_pop |=> mem_space != CRG_SP_IRAM)
    else $error("direct upper address reached RAM");
  a_xri_page: assert property ( // RL22
    mem_req && mem_mode == CRG_AM_XRI && !stk_push && !stk_pop |=>
    mem_addr == {7'h00, $past(st_reg.ext_ram_page_select),
    $past(mem_offset)} && mem_space == CRG_SP_XRAM)
    else $error("external register address wrong");
  c_push_pop: cover property (stk_push ##[1:3] stk_pop);
  c_wide_mult: cover property (alu_go && alu_op == CRG_OP_MULT &&
    st_reg.product_width_select);
  c_second_ptr: cover property (mem_req && mem_mode == CRG_AM_XPTR &&
    st_reg.pointer_select_bit);
endmodule

`default_nettype wire

// ==== verif/test_crg_core_regs.sv ====
// Self-checking bench for the core register and addressing block.
// Assumes crg_pkg and crg_core_regs are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module test_crg_core_regs
  import crg_pkg::*;
;
  // Stimulus, driven on the falling edge
  logic        core_clk    = 1'b0;
  logic        sys_rst     = 1'b1;
  logic [7:0]  sfr_addr    = 8'h00;
  logic [7:0]  sfr_wdata   = 8'h00;
  logic        sfr_wr      = 1'b0;
  logic        sfr_rd      = 1'b0;
  logic        alu_go      = 1'b0;
  crg_op_t     alu_op      = CRG_OP_ADD;
  logic [7:0]  alu_operand = 8'h00;
  logic        first_data_pointer_load   = 1'b0;
  logic [15:0] first_data_pointer_value  = 16'h0000;
  logic        stk_push    = 1'b0;
  logic        stk_pop     = 1'b0;
  logic        mem_req     = 1'b0;
  crg_mode_t   mem_mode    = CRG_AM_DIRECT;
  logic [7:0]  mem_offset  = 8'h00;
  // Observed outputs
  logic [7:0]  sfr_rdata;
  logic [15:0] first_data_pointer_active;
  logic [15:0] mem_addr;
  crg_space_t  mem_space;
  logic        mem_valid;
  logic [7:0]  accumulator_out;
  logic        parity_flag;
  logic        carry_out;
  // Bookkeeping
  int          err_total   = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  // One arithmetic case: preloads, operation, expected results
  typedef struct {
    crg_op_t    op;
    logic [7:0] a, b, st, opnd, ea, ra, re;
    logic       ec;
  } crg_row_t;

  crg_row_t rows [10] = '{
    '{CRG_OP_ADD,  8'hff, 8'h00, 8'h00, 8'h01, 8'h00, 8'hd0, 8'hc0, 1'b1},
    '{CRG_OP_ADD,  8'h7f, 8'h00, 8'h00, 8'h01, 8'h80, 8'hd0, 8'h45, 1'b0},
    '{CRG_OP_ADDC, 8'h10, 8'h00, 8'h80, 8'h20, 8'h31, 8'hd0, 8'h01, 1'b0},
    '{CRG_OP_SUBB, 8'h10, 8'h00, 8'h00, 8'h20, 8'hf0, 8'hd0, 8'h80, 1'b1},
    '{CRG_OP_MULT, 8'h10, 8'h20, 8'h80, 8'h00, 8'h00, 8'hf0, 8'h02, 1'b0},
    '{CRG_OP_QUOT, 8'h64, 8'h07, 8'h00, 8'h00, 8'h0e, 8'hf0, 8'h02, 1'b0},
    '{CRG_OP_QUOT, 8'h05, 8'h00, 8'h00, 8'h00, 8'h05, 8'hd0, 8'h04, 1'b0},
    '{CRG_OP_AND,  8'hf0, 8'h00, 8'h80, 8'h3c, 8'h30, 8'hd0, 8'h80, 1'b1},
    '{CRG_OP_OR,   8'hf0, 8'h00, 8'h00, 8'h0f, 8'hff, 8'hd0, 8'h00, 1'b0},
    '{CRG_OP_XOR,  8'hff, 8'h00, 8'h80, 8'h0f, 8'hf0, 8'hd0, 8'h80, 1'b1}
  };

  crg_core_regs u_crg_core_regs (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .sfr_addr        (sfr_addr),
    .sfr_wdata       (sfr_wdata),
    .sfr_wr          (sfr_wr),
    .sfr_rd          (sfr_rd),
    .sfr_rdata       (sfr_rdata),
    .alu_go          (alu_go),
    .alu_op          (alu_op),
    .alu_operand     (alu_operand),
    .first_data_pointer_load       (first_data_pointer_load),
    .first_data_pointer_value      (first_data_pointer_value),
    .first_data_pointer_active     (first_data_pointer_active),
    .stk_push        (stk_push),
    .stk_pop         (stk_pop),
    .mem_req         (mem_req),
    .mem_mode        (mem_mode),
    .mem_offset      (mem_offset),
    .mem_addr        (mem_addr),
    .mem_space       (mem_space),
    .mem_valid       (mem_valid),
    .accumulator_out (accumulator_out),
    .parity_flag     (parity_flag),
    .carry_out       (carry_out)
  );

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  // Prints the counts and the verdict, then stops
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short; the run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  // Four-state comparison with counting
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write: strobe held for one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask

  // Register read: data registered on the strobe's rising edge, checked at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask

  // One arithmetic strobe
  task automatic alu(input crg_op_t op, input logic [7:0] o);
    @(negedge core_clk);
    alu_go = 1'b1;
    alu_op = op;
    alu_operand = o;
    @(negedge core_clk);
    alu_go = 1'b0;
  endtask

  // Decode (k=0), push (k=1) or pop (k=2), then check the answer
  task automatic mem(input int k, input crg_mode_t m, input logic [7:0] o,
                     input logic [15:0] ea, input crg_space_t es);
    @(negedge core_clk);
    mem_req = (k == 0);
    stk_push = (k == 1);
    stk_pop = (k == 2);
    mem_mode = m;
    mem_offset = o;
    @(negedge core_clk);
    {mem_req, stk_push, stk_pop} = 3'h0;
    chk(mem_valid, 1'b1);
    chk(mem_space, es);
    if (es != CRG_SP_NONE) begin
      chk(mem_addr, ea);
    end
  endtask

  // Main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      wr(CRG_ADR_ACCUM, rows[i].a);
      wr(CRG_ADR_OPND, rows[i].b);
      wr(CRG_ADR_STATUS, rows[i].st);
      alu(rows[i].op, rows[i].opnd);
      chk(accumulator_out, rows[i].ea);
      chk(carry_out, rows[i].ec);
      chk(parity_flag, ^rows[i].ea);
      rd(rows[i].ra, rows[i].re);
    end
    // Stack walk, including a push up to the top of RAM
    mem(1, CRG_AM_DIRECT, 8'h00, 16'h0008, CRG_SP_IRAM);
    mem(1, CRG_AM_DIRECT, 8'h00, 16'h0009, CRG_SP_IRAM);
    mem(2, CRG_AM_DIRECT, 8'h00, 16'h0009, CRG_SP_IRAM);
    rd(CRG_ADR_STACK, 8'h08);
    wr(CRG_ADR_STACK, 8'hfe);
    mem(1, CRG_AM_DIRECT, 8'h00, 16'h00ff, CRG_SP_IRAM);
    // Working-register banks
    for (int i = 0; i < 4; i++) begin
      wr(CRG_ADR_STATUS, 8'(i * 8));
      mem(0, CRG_AM_BANKREG, 8'h05, 16'(i * 8 + 5), CRG_SP_IRAM);
    end
    // Direct, indirect and unused register addresses
    mem(0, CRG_AM_DIRECT, 8'h7f, 16'h007f, CRG_SP_IRAM);
    mem(0, CRG_AM_INDIRECT, 8'h7f, 16'h007f, CRG_SP_IRAM);
    mem(0, CRG_AM_INDIRECT, 8'h90, 16'h0090, CRG_SP_IRAM);
    mem(0, CRG_AM_DIRECT, 8'he0, 16'h00e0, CRG_SP_SFR);
    mem(0, CRG_AM_DIRECT, 8'h80, 16'h0000, CRG_SP_NONE);
    wr(8'h80, 8'h55);
    rd(8'h80, 8'h00);
    // User flags writable, parity bit not
    wr(CRG_ADR_ACCUM, 8'h00);
    wr(CRG_ADR_STATUS, 8'h23);
    rd(CRG_ADR_STATUS, 8'h22);
    wr(CRG_ADR_ACCUM, 8'h01);
    rd(CRG_ADR_STATUS, 8'h23);
    // Page bit and external addressing
    wr(CRG_ADR_EXT_RAM_PAGE_SELECT, 8'hff);
    rd(CRG_ADR_EXT_RAM_PAGE_SELECT, 8'h01);
    mem(0, CRG_AM_XRI, 8'h34, 16'h0134, CRG_SP_XRAM);
    wr(CRG_ADR_PLO0, 8'hcd);
    wr(CRG_ADR_PHI0, 8'hab);
    chk(first_data_pointer_active, 16'habcd);
    wr(CRG_ADR_ICFG, 8'h01);
    chk(first_data_pointer_active, 16'h0000);
    @(negedge core_clk);
    first_data_pointer_load = 1'b1;
    first_data_pointer_value = 16'h1234;
    @(negedge core_clk);
    first_data_pointer_load = 1'b0;
    chk(first_data_pointer_active, 16'h1234);
    mem(0, CRG_AM_XPTR, 8'h00, 16'h1234, CRG_SP_XRAM);
    rd(CRG_ADR_PHI1, 8'h12);
    wr(CRG_ADR_ICFG, 8'h00);
    chk(first_data_pointer_active, 16'habcd);
    // Wide multiply: 1234h times 56h
    wr(CRG_ADR_ICFG, 8'h04);
    wr(CRG_ADR_EXTOP, 8'h12);
    wr(CRG_ADR_ACCUM, 8'h34);
    wr(CRG_ADR_OPND, 8'h56);
    alu(CRG_OP_MULT, 8'h00);
    chk(accumulator_out, 8'h78);
    rd(CRG_ADR_OPND, 8'h1d);
    rd(CRG_ADR_EXTOP, 8'h06);
    // Wide divide: 1234h by 10h
    wr(CRG_ADR_ICFG, 8'h08);
    wr(CRG_ADR_EXTOP, 8'h12);
    wr(CRG_ADR_ACCUM, 8'h34);
    wr(CRG_ADR_OPND, 8'h10);
    alu(CRG_OP_QUOT, 8'h00);
    chk(accumulator_out, 8'h23);
    rd(CRG_ADR_OPND, 8'h04);
    rd(CRG_ADR_EXTOP, 8'h01);
    // Reset in mid-run restores defaults
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(mem_valid, 1'b0);
    chk(accumulator_out, 8'h00);
    chk(sfr_rdata, 8'h00);
    chk(mem_space, CRG_SP_NONE);
    rd(CRG_ADR_STACK, 8'h07);
    rd(CRG_ADR_ICFG, 8'h00);
    rd(CRG_ADR_STATUS, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
